//--- core/dac_drc_beep_pkg.sv
package dac_drc_beep_pkg;

	// control register offsets
	localparam logic [7:0] ADDR_THRESHOLD_CTRL = 8'h44;
	localparam logic [7:0] ADDR_HOLD_CTRL      = 8'h45;
	localparam logic [7:0] ADDR_RATE_CTRL      = 8'h46;
	localparam logic [7:0] ADDR_TONE_CTRL      = 8'h47;
	localparam logic [7:0] ADDR_TONE_LEN_HI    = 8'h49;
	localparam logic [7:0] ADDR_TONE_LEN_MID   = 8'h4a;
	localparam logic [7:0] ADDR_TONE_LEN_LO    = 8'h4b;
	localparam logic [7:0] ADDR_TONE_SIN_HI    = 8'h4c;
	localparam logic [7:0] ADDR_TONE_SIN_LO    = 8'h4d;
	localparam logic [7:0] ADDR_TONE_COS_HI    = 8'h4e;
	localparam logic [7:0] ADDR_TONE_COS_LO    = 8'h4f;

	// reset values
	localparam logic [7:0] RST_THRESHOLD_CTRL = 8'h6f;
	localparam logic [7:0] RST_HOLD_CTRL      = 8'h38;
	localparam logic [7:0] RST_RATE_CTRL      = 8'h00;
	localparam logic [7:0] RST_TONE_CTRL      = 8'h00;
	localparam logic [7:0] RST_TONE_LEN_HI    = 8'h00;
	localparam logic [7:0] RST_TONE_LEN_MID   = 8'h00;
	localparam logic [7:0] RST_TONE_LEN_LO    = 8'hee;
	localparam logic [7:0] RST_TONE_SIN_HI    = 8'h10;
	localparam logic [7:0] RST_TONE_SIN_LO    = 8'hd8;
	localparam logic [7:0] RST_TONE_COS_HI    = 8'h7e;
	localparam logic [7:0] RST_TONE_COS_LO    = 8'he3;

	// field positions
	localparam int CMP_EN_BIT    = 6;
	localparam int THR_LSB       = 2;
	localparam int HYST_LSB      = 0;
	localparam int HOLD_LSB      = 3;
	localparam int ATTACK_LSB    = 4;
	localparam int DECAY_LSB     = 0;
	localparam int TONE_EN_BIT   = 7;
	localparam int TONE_VOL_LSB  = 0;
	localparam logic [7:0] HOLD_WRITE_MASK = 8'h78;

	localparam logic [4:0] TONE_VARIANT = 5'h19;

	// linear levels, full scale 16'h7fff
	localparam logic [15:0] THRESHOLD_LIN [8] = '{16'h5a9d, 16'h4027,
		16'h2d6b, 16'h2027, 16'h16c3, 16'h101d, 16'h0b68, 16'h0814};
	localparam logic [15:0] HYST_FACTOR [4] = '{16'h7fff, 16'h7215,
		16'h65ad, 16'h5a9e};
	localparam logic [15:0] DB_STEP_LIN [6] = '{16'h7fff, 16'h7215,
		16'h65ad, 16'h5a9e, 16'h50c3, 16'h47fb};
	localparam logic [7:0] DB_PER_SHIFT = 8'h06;

	// timing in word clocks, gain in dB with 24 fraction bits
	localparam logic [17:0] HOLD_BASE_WC = 18'h00020;
	localparam logic [17:0] HOLD_LONG_WC = 18'h08000;
	localparam logic [31:0] ATTACK_MAX_Q = 32'h0400_0000;
	localparam logic [31:0] DECAY_MAX_Q  = 32'h0004_0000;
	localparam logic [31:0] GR_LIMIT_Q   = 32'h3c00_0000;

	typedef struct packed {
		logic signed [15:0] data;
	} sample_t;

	typedef struct packed {
		logic       write;
		logic       read;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef enum logic [3:0] {
		CMP_IDLE   = 4'b0001,
		CMP_ATTACK = 4'b0010,
		CMP_HOLD   = 4'b0100,
		CMP_DECAY  = 4'b1000
	} cmp_state_t;

endpackage

//--- core/dac_dynamic_range_and_beep.sv
// Overview of operation
// - compressor acts on samples only while enabled; enabled at reset
// - threshold code 0..7 gives -3 dB down to -24 dB; reset -12 dB
// - hysteresis code gives 0 to 3 dB; reset 3 dB
// - hold code 0 disables hold; codes 1..5 give 32 to 512 words
// - hold codes 14 and 15 give 4x and 5x 32768 word clocks
// - attack rate 4 dB per word at code 0, halving each step
// - decay rate 1.5625e-2 dB per word at code 0, halving each step
// - writing tone enable starts tone; clears itself after length; 0 stops
// - tone volume +2 dB at code 0, down 1 dB per step
// - tone only produced when processing variant 25 is selected
// - tone length is 24-bit sample count from three registers
// - tone frequency set by 16-bit sine and cosine coefficients
`timescale 1ns/1ps

module sample_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic             clkEn,
	// fill side
	input  wire logic             inValid,
	input  wire logic [WIDTH-1:0] inData,
	output      logic             inReady,
	// drain side
	output      logic             outValid,
	output      logic [WIDTH-1:0] outData,
	input  wire logic             outReady,
	// fill level
	output      logic [$clog2(DEPTH+1)-1:0] level
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr_q;
	logic [AW-1:0]    rdPtr_q;
	logic [AW:0]      count_q;
	logic             outValid_q;
	logic [WIDTH-1:0] outData_q;
	logic             push;
	logic             pop;

	// output stage is a register so the drain side sees flop outputs
	assign inReady  = (count_q != DEPTH[AW:0]);
	assign push     = inValid && inReady;
	assign pop      = (count_q != '0) && (!outValid_q || outReady);
	assign outValid = outValid_q;
	assign outData  = outData_q;
	assign level    = count_q;

	always_ff @(posedge clk) begin
		if (clkEn && push) begin
			mem[wrPtr_q] <= inData;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else if (clkEn) begin
			if (push) begin
				wrPtr_q <= wrPtr_q + 1'b1;
			end
			if (pop) begin
				rdPtr_q <= rdPtr_q + 1'b1;
			end
			if (push && !pop) begin
				count_q <= count_q + 1'b1;
			end else if (pop && !push) begin
				count_q <= count_q - 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			outValid_q <= 1'b0;
			outData_q  <= '0;
		end else if (clkEn) begin
			if (pop) begin
				outValid_q <= 1'b1;
				outData_q  <= mem[rdPtr_q];
			end else if (outReady) begin
				outValid_q <= 1'b0;
			end
		end
	end

endmodule

module dac_dynamic_range_and_beep #(
	parameter int FIFO_DEPTH = 16
) (
	// clock and reset
	input  wire logic                       clk,
	input  wire logic                       resetn,
	input  wire logic                       clkEn,
	// register port from the control serial bus
	input  wire dac_drc_beep_pkg::reg_req_t regReq,
	output      logic [7:0]                 regRdata,
	// processing block selection
	input  wire logic [4:0]                 dacProcessingVariant,
	// samples from the data path
	input  wire logic                       sampleInValid,
	input  wire dac_drc_beep_pkg::sample_t  sampleIn,
	output      logic                       sampleInReady,
	// samples toward the converter
	output      logic                       sampleOutValid,
	output      dac_drc_beep_pkg::sample_t  sampleOut,
	input  wire logic                       sampleOutReady
);
	localparam int LW = $clog2(FIFO_DEPTH + 1);

	logic [7:0] thresholdCtrl_q;
	logic [7:0] holdCtrl_q;
	logic [7:0] rateCtrl_q;
	logic [7:0] toneCtrl_q;
	logic [7:0] toneLenHi_q;
	logic [7:0] toneLenMid_q;
	logic [7:0] toneLenLo_q;
	logic [7:0] toneSinHi_q;
	logic [7:0] toneSinLo_q;
	logic [7:0] toneCosHi_q;
	logic [7:0] toneCosLo_q;
	logic [7:0] regRdata_q;
	logic       toneEn_q;
	logic [23:0] toneLeft_q;
	logic signed [15:0] toneCur_q;
	logic signed [15:0] tonePrev_q;
	logic [31:0] gainRed_q;
	logic [17:0] holdCnt_q;
	dac_drc_beep_pkg::cmp_state_t cmpState_q;
	logic       stageValid_q;
	logic [15:0] stageData_q;
	logic       inReady_q;

	logic       wordClk;
	logic       regWr;
	logic       toneStart;
	logic       cmpEn;
	logic       fifoInReady;
	logic [LW-1:0] fifoLevel;
	logic [15:0] fifoOutData;
	logic [15:0] gainLin;
	logic [15:0] volLin;
	logic [15:0] thrLin;
	logic [15:0] lowLin;
	logic [31:0] lowProd;
	logic [16:0] magnitude;
	logic [17:0] holdLen;
	logic [31:0] attackStep;
	logic [31:0] decayStep;
	logic signed [32:0] gainedProd;
	logic signed [32:0] toneProd;
	logic signed [31:0] oscProd;
	logic signed [15:0] gained;
	logic signed [15:0] toneScaled;
	logic signed [16:0] mixSum;
	logic [15:0] mixed;
	logic        toneActive;

	// gain in whole dB to linear: 6 dB per shift plus a fraction step
	function automatic logic [15:0] dbToLin(input logic [7:0] db);
		logic [7:0] shiftAmt;
		logic [7:0] remDb;
		shiftAmt = db / dac_drc_beep_pkg::DB_PER_SHIFT;
		remDb    = db % dac_drc_beep_pkg::DB_PER_SHIFT;
		dbToLin  = dac_drc_beep_pkg::DB_STEP_LIN[remDb[2:0]] >> shiftAmt;
	endfunction

	// codes 6..13 continue the doubling, nothing else defines them
	function automatic logic [17:0] holdWords(input logic [3:0] code);
		case (code)
			4'h0: holdWords = '0;
			4'he: holdWords = dac_drc_beep_pkg::HOLD_LONG_WC << 2;
			4'hf: holdWords = (dac_drc_beep_pkg::HOLD_LONG_WC << 2)
				+ dac_drc_beep_pkg::HOLD_LONG_WC;
			default: holdWords = dac_drc_beep_pkg::HOLD_BASE_WC
				<< (code - 4'h1);
		endcase
	endfunction

	// one accepted sample is one word clock
	assign wordClk = clkEn && sampleInValid && inReady_q
		&& (!stageValid_q || fifoInReady);
	assign regWr     = clkEn && regReq.write;
	assign toneStart = regWr && (regReq.addr == dac_drc_beep_pkg::ADDR_TONE_CTRL)
		&& regReq.wdata[dac_drc_beep_pkg::TONE_EN_BIT];
	assign cmpEn = thresholdCtrl_q[dac_drc_beep_pkg::CMP_EN_BIT];

	assign thrLin = dac_drc_beep_pkg::THRESHOLD_LIN[
		thresholdCtrl_q[dac_drc_beep_pkg::THR_LSB +: 3]];
	assign lowProd = thrLin * dac_drc_beep_pkg::HYST_FACTOR[
		thresholdCtrl_q[dac_drc_beep_pkg::HYST_LSB +: 2]];
	assign lowLin  = lowProd[30:15];
	assign holdLen = holdWords(holdCtrl_q[dac_drc_beep_pkg::HOLD_LSB +: 4]);
	assign attackStep = dac_drc_beep_pkg::ATTACK_MAX_Q
		>> rateCtrl_q[dac_drc_beep_pkg::ATTACK_LSB +: 4];
	assign decayStep  = dac_drc_beep_pkg::DECAY_MAX_Q
		>> rateCtrl_q[dac_drc_beep_pkg::DECAY_LSB +: 4];

	// disabled compressor passes samples untouched
	assign gainLin = cmpEn ? dbToLin(gainRed_q[31:24])
		: 16'h7fff;
	assign gainedProd = $signed(sampleIn.data) * $signed({1'b0, gainLin});
	// unity skips the multiplier, whose 7fff scale would lose an lsb
	assign gained     = (gainLin == 16'h7fff) ? sampleIn.data
		: gainedProd[30:15];
	assign magnitude  = gained[15] ? 17'(-$signed({gained[15], gained}))
		: {1'b0, gained};

	// code 0 is +2 dB: the oscillator peak stands for that level
	assign volLin = dbToLin({2'b00,
		toneCtrl_q[dac_drc_beep_pkg::TONE_VOL_LSB +: 6]});
	assign toneProd   = $signed(toneCur_q) * $signed({1'b0, volLin});
	assign toneScaled = toneProd[30:15];
	assign toneActive = toneEn_q
		&& (dacProcessingVariant == dac_drc_beep_pkg::TONE_VARIANT);
	assign mixSum = toneActive ? 17'(gained + toneScaled)
		: {gained[15], gained};
	// saturate rather than wrap when tone rides on a loud sample
	assign mixed = (mixSum[16] != mixSum[15])
		? (mixSum[16] ? 16'h8000 : 16'h7fff) : mixSum[15:0];

	// second-order resonator: next = 2 cos * cur - prev
	assign oscProd = $signed({toneCosHi_q, toneCosLo_q}) * toneCur_q;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			thresholdCtrl_q <= dac_drc_beep_pkg::RST_THRESHOLD_CTRL;
			holdCtrl_q      <= dac_drc_beep_pkg::RST_HOLD_CTRL;
			rateCtrl_q      <= dac_drc_beep_pkg::RST_RATE_CTRL;
			toneLenHi_q     <= dac_drc_beep_pkg::RST_TONE_LEN_HI;
			toneLenMid_q    <= dac_drc_beep_pkg::RST_TONE_LEN_MID;
			toneLenLo_q     <= dac_drc_beep_pkg::RST_TONE_LEN_LO;
			toneSinHi_q     <= dac_drc_beep_pkg::RST_TONE_SIN_HI;
			toneSinLo_q     <= dac_drc_beep_pkg::RST_TONE_SIN_LO;
			toneCosHi_q     <= dac_drc_beep_pkg::RST_TONE_COS_HI;
			toneCosLo_q     <= dac_drc_beep_pkg::RST_TONE_COS_LO;
		end else if (regWr) begin
			// reserved bits are stored as written, except hold control, whose write mask clears them; host keeps them at reset
			case (regReq.addr)
				dac_drc_beep_pkg::ADDR_THRESHOLD_CTRL: begin
					thresholdCtrl_q <= regReq.wdata;
				end
				dac_drc_beep_pkg::ADDR_HOLD_CTRL: begin
					holdCtrl_q <= regReq.wdata
						& dac_drc_beep_pkg::HOLD_WRITE_MASK;
				end
				dac_drc_beep_pkg::ADDR_RATE_CTRL: rateCtrl_q <= regReq.wdata;
				dac_drc_beep_pkg::ADDR_TONE_LEN_HI: toneLenHi_q <= regReq.wdata;
				dac_drc_beep_pkg::ADDR_TONE_LEN_MID: begin
					toneLenMid_q <= regReq.wdata;
				end
				dac_drc_beep_pkg::ADDR_TONE_LEN_LO: toneLenLo_q <= regReq.wdata;
				dac_drc_beep_pkg::ADDR_TONE_SIN_HI: toneSinHi_q <= regReq.wdata;
				dac_drc_beep_pkg::ADDR_TONE_SIN_LO: toneSinLo_q <= regReq.wdata;
				dac_drc_beep_pkg::ADDR_TONE_COS_HI: toneCosHi_q <= regReq.wdata;
				dac_drc_beep_pkg::ADDR_TONE_COS_LO: toneCosLo_q <= regReq.wdata;
				default: begin
				end
			endcase
		end
	end

	// volume and reserved bits; enable lives in its own flop
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			toneCtrl_q <= dac_drc_beep_pkg::RST_TONE_CTRL;
		end else if (regWr && regReq.addr == dac_drc_beep_pkg::ADDR_TONE_CTRL) begin
			toneCtrl_q <= regReq.wdata;
		end
	end

	// a start write in the same cycle as the self-clear wins
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			toneEn_q   <= 1'b0;
			toneLeft_q <= '0;
			toneCur_q  <= '0;
			tonePrev_q <= '0;
		end else if (regWr && regReq.addr == dac_drc_beep_pkg::ADDR_TONE_CTRL) begin
			toneEn_q   <= toneStart;
			toneLeft_q <= {toneLenHi_q, toneLenMid_q, toneLenLo_q};
			toneCur_q  <= $signed({toneSinHi_q, toneSinLo_q});
			tonePrev_q <= '0;
		end else if (wordClk && toneEn_q) begin
			if (toneLeft_q <= 24'h000001) begin
				toneEn_q <= 1'b0;
			end
			toneLeft_q <= (toneLeft_q == '0) ? '0
				: toneLeft_q - 24'h000001;
			toneCur_q  <= 16'(oscProd[29:14] - tonePrev_q);
			tonePrev_q <= toneCur_q;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cmpState_q <= dac_drc_beep_pkg::CMP_IDLE;
			gainRed_q  <= '0;
			holdCnt_q  <= '0;
		end else if (clkEn && !cmpEn) begin
			cmpState_q <= dac_drc_beep_pkg::CMP_IDLE;
			gainRed_q  <= '0;
			holdCnt_q  <= '0;
		end else if (wordClk) begin
			case (cmpState_q)
				dac_drc_beep_pkg::CMP_IDLE: begin
					if (magnitude > {1'b0, thrLin}) begin
						cmpState_q <= dac_drc_beep_pkg::CMP_ATTACK;
					end
				end
				dac_drc_beep_pkg::CMP_ATTACK: begin
					if (magnitude > {1'b0, thrLin}) begin
						gainRed_q <= (gainRed_q + attackStep
							> dac_drc_beep_pkg::GR_LIMIT_Q)
							? dac_drc_beep_pkg::GR_LIMIT_Q
							: gainRed_q + attackStep;
					end else begin
						cmpState_q <= dac_drc_beep_pkg::CMP_HOLD;
						holdCnt_q  <= holdLen;
					end
				end
				dac_drc_beep_pkg::CMP_HOLD: begin
					if (magnitude > {1'b0, thrLin}) begin
						cmpState_q <= dac_drc_beep_pkg::CMP_ATTACK;
					end else if (holdCnt_q != '0) begin
						holdCnt_q <= holdCnt_q - 18'h00001;
					end else if (magnitude < {1'b0, lowLin}) begin
						cmpState_q <= dac_drc_beep_pkg::CMP_DECAY;
					end
				end
				dac_drc_beep_pkg::CMP_DECAY: begin
					if (magnitude > {1'b0, thrLin}) begin
						cmpState_q <= dac_drc_beep_pkg::CMP_ATTACK;
					end else if (magnitude < {1'b0, lowLin}) begin
						if (gainRed_q <= decayStep) begin
							gainRed_q  <= '0;
							cmpState_q <= dac_drc_beep_pkg::CMP_IDLE;
						end else begin
							gainRed_q <= gainRed_q - decayStep;
						end
					end
				end
				default: cmpState_q <= dac_drc_beep_pkg::CMP_IDLE;
			endcase
		end
	end

	// one processed sample waits here for room in the buffer
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			stageValid_q <= 1'b0;
			stageData_q  <= '0;
		end else if (clkEn) begin
			if (wordClk) begin
				stageValid_q <= 1'b1;
				stageData_q  <= mixed;
			end else if (fifoInReady) begin
				stageValid_q <= 1'b0;
			end
		end
	end

	// margin of two covers the staged sample and one already accepted
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			inReady_q <= 1'b0;
		end else if (clkEn) begin
			inReady_q <= (fifoLevel < LW'(FIFO_DEPTH - 2));
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			regRdata_q <= '0;
		end else if (clkEn && regReq.read) begin
			case (regReq.addr)
				dac_drc_beep_pkg::ADDR_THRESHOLD_CTRL: regRdata_q <= thresholdCtrl_q;
				dac_drc_beep_pkg::ADDR_HOLD_CTRL: regRdata_q <= holdCtrl_q;
				dac_drc_beep_pkg::ADDR_RATE_CTRL: regRdata_q <= rateCtrl_q;
				dac_drc_beep_pkg::ADDR_TONE_CTRL: begin
					regRdata_q <= {toneEn_q, toneCtrl_q[6:0]};
				end
				dac_drc_beep_pkg::ADDR_TONE_LEN_HI: regRdata_q <= toneLenHi_q;
				dac_drc_beep_pkg::ADDR_TONE_LEN_MID: regRdata_q <= toneLenMid_q;
				dac_drc_beep_pkg::ADDR_TONE_LEN_LO: regRdata_q <= toneLenLo_q;
				dac_drc_beep_pkg::ADDR_TONE_SIN_HI: regRdata_q <= toneSinHi_q;
				dac_drc_beep_pkg::ADDR_TONE_SIN_LO: regRdata_q <= toneSinLo_q;
				dac_drc_beep_pkg::ADDR_TONE_COS_HI: regRdata_q <= toneCosHi_q;
				dac_drc_beep_pkg::ADDR_TONE_COS_LO: regRdata_q <= toneCosLo_q;
				default: regRdata_q <= '0;
			endcase
		end
	end

	sample_fifo #(
		.WIDTH (16),
		.DEPTH (FIFO_DEPTH)
	) outFifo (
		.clk      (clk),
		.resetn   (resetn),
		.clkEn    (clkEn),
		.inValid  (stageValid_q),
		.inData   (stageData_q),
		.inReady  (fifoInReady),
		.outValid (sampleOutValid),
		.outData  (fifoOutData),
		.outReady (sampleOutReady),
		.level    (fifoLevel)
	);

	assign sampleOut.data = fifoOutData;
	assign sampleInReady  = inReady_q;
	assign regRdata       = regRdata_q;

endmodule

//--- test/dac_drc_beep_monitor.sv
`timescale 1ns/1ps
module dac_drc_beep_monitor #(
	parameter int FIFO_DEPTH = 16
) (
	// clock and reset
	input wire logic                       clk,
	input wire logic                       resetn,
	input wire logic                       clkEn,
	// register port
	input wire dac_drc_beep_pkg::reg_req_t regReq,
	input wire logic [7:0]                 regRdata,
	// processing selection
	input wire logic [4:0]                 dacProcessingVariant,
	// sample stream
	input wire logic                       sampleInValid,
	input wire dac_drc_beep_pkg::sample_t  sampleIn,
	input wire logic                       sampleInReady,
	input wire logic                       sampleOutValid,
	input wire dac_drc_beep_pkg::sample_t  sampleOut,
	input wire logic                       sampleOutReady
);
	logic       takeIn;
	logic       takeOut;
	logic       rdTake;
	logic       wrTake;
	logic       rb;
	logic [8:0] lastWr_q;
	logic [7:0] pending_q;

	assign takeIn = clkEn && sampleInValid && sampleInReady;
	assign takeOut = clkEn && sampleOutValid && sampleOutReady;
	assign rdTake = clkEn && regReq.read && !regReq.write;
	assign wrTake = clkEn && regReq.write && !regReq.read;
	// read of the address written the cycle before
	assign rb = rdTake && lastWr_q == {1'b1, regReq.addr};

	// samples inside; the tone never makes samples of its own
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pending_q <= 8'h00;
		end else begin
			pending_q <= pending_q + 8'(takeIn) - 8'(takeOut);
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			lastWr_q <= 9'h000;
		end else begin
			lastWr_q <= wrTake ? {1'b1, regReq.addr} : 9'h000;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	AST_THR_READBACK: assert property (
		rb && regReq.addr == dac_drc_beep_pkg::ADDR_THRESHOLD_CTRL
		|=> regRdata == $past(regReq.wdata, 2)) else $error("threshold readback");
	AST_HOLD_READBACK: assert property (
		rb && regReq.addr == dac_drc_beep_pkg::ADDR_HOLD_CTRL
		|=> regRdata == ($past(regReq.wdata, 2) & 8'h78))
		else $error("hold readback");
	AST_RATE_READBACK: assert property (
		rb && regReq.addr == dac_drc_beep_pkg::ADDR_RATE_CTRL
		|=> regRdata == $past(regReq.wdata, 2)) else $error("rate readback");
	AST_TONE_START: assert property (
		rb && regReq.addr == dac_drc_beep_pkg::ADDR_TONE_CTRL && !takeIn
		&& $past(regReq.wdata[7]) && !$past(takeIn) |=> regRdata[7])
		else $error("tone enable not set");
	AST_TONE_STOP: assert property (
		rb && regReq.addr == dac_drc_beep_pkg::ADDR_TONE_CTRL
		&& !$past(regReq.wdata[7]) |=> !regRdata[7]) else $error("tone not off");
	AST_UNMAPPED_ZERO: assert property (
		rdTake && (regReq.addr < 8'h44 || regReq.addr == 8'h48
		|| regReq.addr > 8'h4f) |=> regRdata == 8'h00) else $error("unmapped");
	AST_RDATA_STABLE: assert property (
		!(clkEn && regReq.read) |=> $stable(regRdata)) else $error("rdata moved");
	AST_OUT_HOLD: assert property (
		sampleOutValid && !(sampleOutReady && clkEn)
		|=> sampleOutValid && $stable(sampleOut)) else $error("output dropped");
	AST_NO_SPURIOUS: assert property (
		sampleOutValid |-> pending_q != 8'h00) else $error("spare sample");
	AST_LATENCY: assert property (
		takeIn && pending_q == 8'h00 ##1 clkEn [*3] |-> sampleOutValid)
		else $error("sample late");
endmodule

bind dac_dynamic_range_and_beep dac_drc_beep_monitor #(
	.FIFO_DEPTH(FIFO_DEPTH)
) mon_u (
	.clk(clk),
	.resetn(resetn),
	.clkEn(clkEn),
	.regReq(regReq),
	.regRdata(regRdata),
	.dacProcessingVariant(dacProcessingVariant),
	.sampleInValid(sampleInValid),
	.sampleIn(sampleIn),
	.sampleInReady(sampleInReady),
	.sampleOutValid(sampleOutValid),
	.sampleOut(sampleOut),
	.sampleOutReady(sampleOutReady)
);

//--- test/sample_far_side.sv
`timescale 1ns/1ps
module sample_far_side (
	// clock and reset
	input wire logic                      clk,
	input wire logic                      resetn,
	input wire logic                      clkEn,
	// bench control
	input wire logic                      stall,
	// toward the block
	output     logic                      sampleInValid,
	output     dac_drc_beep_pkg::sample_t sampleIn,
	input wire logic                      sampleInReady,
	// from the block
	input wire logic                      sampleOutValid,
	output     logic                      sampleOutReady
);
	int seed = 32'hdb838cc4;

	initial begin
		sampleInValid = 1'b0;
		sampleIn = '0;
		sampleOutReady = 1'b0;
	end

	// the converter side pauses at random, so the buffer sees stalls
	always @(posedge clk) begin
		sampleOutReady <= !stall && ($random(seed) % 4 != 0);
	end

	// word held until taken; valid stays up for back to back words
	task automatic send(input logic [15:0] x);
		sampleInValid <= 1'b1;
		sampleIn.data <= x;
		@(posedge clk);
		while (!(sampleInReady && clkEn && resetn)) @(posedge clk);
	endtask

	// released data shows junk, not the last word
	task automatic idle();
		sampleInValid <= 1'b0;
		sampleIn.data <= ~sampleIn.data;
		@(posedge clk);
	endtask
endmodule

//--- test/dac_dynamic_range_and_beep_bench.sv
`timescale 1ns/1ps
module dac_dynamic_range_and_beep_bench;
	typedef struct {
		logic [15:0] v;
		logic        care;
	} note_t;
	localparam logic [7:0] RST_ADDR [11] = '{8'h44, 8'h45, 8'h46, 8'h47,
		8'h49, 8'h4a, 8'h4b, 8'h4c, 8'h4d, 8'h4e, 8'h4f};
	localparam logic [7:0] RST_VAL [11] = '{8'h6f, 8'h38, 8'h00, 8'h00,
		8'h00, 8'h00, 8'hee, 8'h10, 8'hd8, 8'h7e, 8'he3};

	logic                       clk = 1'b0;
	logic                       resetn = 1'b0;
	logic                       clkEn = 1'b1;
	logic                       stall = 1'b0;
	logic [4:0]                 dacProcessingVariant = 5'h00;
	dac_drc_beep_pkg::reg_req_t regReq = '0;
	logic [7:0]                 regRdata;
	logic                       sampleInValid;
	logic                       sampleInReady;
	logic                       sampleOutValid;
	logic                       sampleOutReady;
	dac_drc_beep_pkg::sample_t  sampleIn;
	dac_drc_beep_pkg::sample_t  sampleOut;
	logic signed [15:0]         lastSeen;
	logic [7:0]                 q;
	logic [7:0]                 d;
	int                         seed = 32'hdb838cc4;
	int                         n_errors = 0;
	int                         compares = 0;
	int                         cycles = 0;
	int                         nDiff = 0;
	note_t                      notes[$];

	always #10 clk = ~clk;

	dac_dynamic_range_and_beep #(.FIFO_DEPTH(16)) dut_u (
		.clk(clk), .resetn(resetn), .clkEn(clkEn), .regReq(regReq),
		.regRdata(regRdata), .dacProcessingVariant(dacProcessingVariant),
		.sampleInValid(sampleInValid), .sampleIn(sampleIn),
		.sampleInReady(sampleInReady), .sampleOutValid(sampleOutValid),
		.sampleOut(sampleOut), .sampleOutReady(sampleOutReady));

	sample_far_side far_u (
		.clk(clk), .resetn(resetn), .clkEn(clkEn), .stall(stall),
		.sampleInValid(sampleInValid), .sampleIn(sampleIn),
		.sampleInReady(sampleInReady), .sampleOutValid(sampleOutValid),
		.sampleOutReady(sampleOutReady));

	task automatic chk(input string what, input logic [15:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wrap_up();
		$display("compares %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// callers stand just after a rising edge; so do the tasks on return
	task automatic rd(input logic [7:0] a, output logic [7:0] r);
		regReq <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk);
		regReq <= '0;
		@(negedge clk);
		r = regRdata;
		@(posedge clk);
	endtask

	// every write is read back at once, so the write never repeats
	task automatic acc(input logic [7:0] a, v, output logic [7:0] r);
		regReq <= '{1'b1, 1'b0, a, v};
		@(posedge clk);
		rd(a, r);
	endtask

	task automatic snd(input logic [15:0] x, input logic care);
		notes.push_back('{x, care});
		far_u.send(x);
	endtask

	task automatic drain();
		far_u.idle();
		for (int i = 0; i < 400 && notes.size() > 0; i++) @(posedge clk);
		chk("drained", 16'(notes.size()), 16'h0000);
	endtask

	always @(posedge clk) begin
		note_t n;
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			wrap_up();
		end
		if (resetn && clkEn && sampleOutValid && sampleOutReady) begin
			if (notes.size() == 0) begin
				chk("spare sample", sampleOut.data, 16'hxxxx);
			end else begin
				n = notes.pop_front();
				lastSeen = sampleOut.data;
				if (n.care) chk("sample", sampleOut.data, n.v);
				else if (sampleOut.data !== n.v) nDiff++;
			end
		end
	end

	initial begin
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 11; i++) begin
			rd(RST_ADDR[i], q);
			chk("reset value", {8'h00, q}, {8'h00, RST_VAL[i]});
		end
		acc(dac_drc_beep_pkg::ADDR_HOLD_CTRL, 8'hff, q);
		chk("hold bits", {8'h00, q}, 16'h0078);
		acc(8'h48, 8'h5a, q);
		chk("unmapped", {8'h00, q}, 16'h0000);
		for (int i = 0; i < 4; i++) begin
			d = 8'($random(seed));
			acc(dac_drc_beep_pkg::ADDR_RATE_CTRL, d, q);
			chk("rate", {8'h00, q}, {8'h00, d});
			// reserved bits keep their reset values
			acc(8'h44, {3'b011, d[4:0]}, q);
			chk("threshold", {8'h00, q}, {11'h003, d[4:0]});
			acc(8'h47, {2'b00, d[5:0]}, q);
			chk("volume", {8'h00, q}, {10'h000, d[5:0]});
		end
		acc(dac_drc_beep_pkg::ADDR_RATE_CTRL, 8'h00, q);
		$display("test registers done");
		acc(8'h44, 8'h2f, q);
		stall <= 1'b1;
		fork
			for (int i = 0; i < 24; i++) snd(16'($random(seed)), 1'b1);
			begin
				repeat (60) @(posedge clk);
				chk("refused", {15'h0, sampleInReady}, 16'h0000);
				stall <= 1'b0;
			end
		join
		drain();
		$display("test bypass done");
		acc(8'h44, 8'h6f, q);
		for (int i = 0; i < 16; i++) begin
			d = 8'($random(seed));
			snd({{8{d[7]}}, d}, 1'b1);
		end
		drain();
		for (int i = 0; i < 12; i++) snd(16'h7fff, 1'b0);
		drain();
		chk("reduced", {15'h0, lastSeen < 16'sh7fff}, 16'h0001);
		$display("test compressor done");
		acc(8'h44, 8'h2f, q);
		acc(8'h4b, 8'h04, q);
		nDiff = 0;
		for (int v = 0; v < 2; v++) begin
			dacProcessingVariant <= v ? 5'h19 : 5'h03;
			acc(8'h47, 8'h80, q);
			chk("tone on", {8'h00, q}, 16'h0080);
			for (int i = 0; i < 3; i++) snd(16'h0010, v == 0);
			drain();
			rd(8'h47, q);
			chk("tone length", {8'h00, q}, 16'h0080);
			snd(16'h0010, v == 0);
			drain();
			rd(8'h47, q);
			chk("tone cleared", {8'h00, q}, 16'h0000);
		end
		chk("tone heard", {15'h0, nDiff > 0}, 16'h0001);
		acc(8'h49, 8'hff, q);
		acc(8'h47, 8'h80, q);
		acc(8'h47, 8'h00, q);
		chk("tone stopped", {8'h00, q}, 16'h0000);
		for (int i = 0; i < 4; i++) snd(16'h0020, 1'b1);
		drain();
		$display("test tone done");
		wrap_up();
	end
endmodule
